/* core/link2_irq_pkg.sv */
package link2_irq_pkg;

	// register addresses on the parallel port
	localparam logic [8:0] ADDR_LINK2_STATUS   = 9'h00a;
	localparam logic [8:0] ADDR_PATTERN_STATUS = 9'h00b;
	localparam logic [8:0] ADDR_ALARM1_ENABLE  = 9'h00c;
	localparam logic [8:0] ADDR_LINK2_ENABLE   = 9'h012;
	localparam logic [8:0] ADDR_PATTERN_ENABLE = 9'h013;

	// link2 status field positions
	localparam int BIT_CODEWORD   = 7;
	localparam int BIT_RX_FULL    = 6;
	localparam int BIT_RX_NEAR    = 5;
	localparam int BIT_MSG_RX     = 4;
	localparam int BIT_TX_UNDER   = 3;
	localparam int BIT_TX_OVER    = 2;
	localparam int BIT_TX_NEAR    = 1;
	localparam int BIT_MSG_SENT   = 0;

	// pattern status field positions
	localparam int BIT_BIT_SLIP   = 5;
	localparam int BIT_PAT_SYNC   = 4;
	localparam int BIT_TX_CRC     = 3;
	localparam int BIT_TX_CAS     = 2;
	localparam int BIT_TX_MF      = 1;
	localparam int BIT_TX_FRAME   = 0;

	// reset values and the pattern register mask
	localparam logic [7:0] RESET_STATUS = 8'h00;
	localparam logic [7:0] RESET_ENABLE = 8'h00;
	localparam logic [7:0] PATTERN_MASK = 8'h3f;

	// pattern sync detector counts, in received bits
	localparam int SYNC_MIN_BITS   = 128;
	localparam int SYNC_CLEAN_BITS = 96;
	// bits per error window for a ratio above 10e-2; the sync detector does not use it
	localparam int BER_WINDOW_BITS = 100;

	localparam logic [7:0] MIN_BITS_CNT   = 8'(SYNC_MIN_BITS);
	localparam logic [7:0] CLEAN_BITS_CNT = 8'(SYNC_CLEAN_BITS);

endpackage

/* core/pattern_sync_detect.sv */
`timescale 1ns/100ps
`default_nettype none

// pattern sync detector: searches after restart, latches sync when found
module pattern_sync_detect
	import link2_irq_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// control and received bits
	input  wire logic restart,
	input  wire logic bit_valid,
	input  wire logic bit_error,
	// status
	output logic      sync,
	output logic      count_error
);

	typedef enum {SEARCH, LOCKED} sync_state_e;

	sync_state_e state_reg, state_next;
	logic [7:0]  since_reg, since_next;
	logic [7:0]  clean_reg, clean_next;

	// a clean run of 96 bits only counts once 128 bits have passed
	always_comb begin
		state_next = state_reg;
		since_next = since_reg;
		clean_next = clean_reg;
		if (restart) begin
			state_next = SEARCH;
			since_next = 8'h00;
			clean_next = 8'h00;
		end else begin
			unique case (state_reg)
				SEARCH: begin
					if (bit_valid) begin
						if (since_reg != MIN_BITS_CNT)
							since_next = since_reg + 8'h01;
						// any error restarts the clean run; a ratio
						// above 10e-2 therefore never reaches 96
						clean_next = bit_error ? 8'h00 :
							(clean_reg == CLEAN_BITS_CNT ?
							 clean_reg : clean_reg + 8'h01);
					end
					if (since_reg == MIN_BITS_CNT &&
					    clean_reg == CLEAN_BITS_CNT)
						state_next = LOCKED;
				end
				LOCKED: ; // stays until next restart
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= SEARCH;
			since_reg <= 8'h00;
			clean_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			since_reg <= since_next;
			clean_reg <= clean_next;
		end
	end

	assign sync        = (state_reg == LOCKED);
	assign count_error = sync && bit_valid && bit_error;

	property p_min_bits;
		@(posedge clk) disable iff (rst)
		restart |=> !sync [*8];
	endproperty
	a_min_bits: assert property (p_min_bits)
		else $error("sync rose too soon after restart");

endmodule
`default_nettype wire

/* core/framer_link2_pattern_irq_status.sv */
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module framer_link2_pattern_irq_status
	import link2_irq_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// parallel register port
	input  wire logic       reg_sel,
	input  wire logic       reg_wr,
	input  wire logic [8:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// link2 receiver conditions
	input  wire logic       codeword_stored,
	input  wire logic       hdlc_mode,
	input  wire logic       rx_overrun_write,
	input  wire logic       rx_fill_at_limit,
	input  wire logic       rx_fill_at_near,
	input  wire logic       rx_msg_available,
	// link2 transmitter conditions
	input  wire logic       tx_fifo_drained,
	input  wire logic       tx_end_mark_seen,
	input  wire logic       tx_write_while_full,
	input  wire logic       tx_below_near,
	input  wire logic       tx_closing_flag,
	// framer and pattern conditions
	input  wire logic       bit_slip_seen,
	input  wire logic       bit_slip_enabled,
	input  wire logic       fas_error_raw,
	input  wire logic       pattern_restart,
	input  wire logic       pattern_bit_valid,
	input  wire logic       pattern_bit_error,
	input  wire logic       tx_crc_fail,
	input  wire logic       tx_cas_fail,
	input  wire logic       cas_mode,
	input  wire logic       tx_mf_fail,
	input  wire logic       tx_frame_fail,
	// results
	output logic            hdlc_abort,
	output logic            tx_data_discard,
	output logic            frame_error_report,
	output logic            pattern_bit_error_count,
	output logic            pattern_sync,
	output logic      [1:0] master_interrupt_bits
);

	////////////////////////////////////////////////////////////////////////////
	// sources and edge detection

	logic [7:0] link2_src, pattern_src;
	logic [7:0] link2_prev_reg, link2_prev_next;
	logic [7:0] pat_prev_reg, pat_prev_next;
	logic       sync_raw, count_raw;

	pattern_sync_detect u_sync (
		.clk         (clk),
		.rst         (rst),
		.restart     (pattern_restart),
		.bit_valid   (pattern_bit_valid),
		.bit_error   (pattern_bit_error),
		.sync        (sync_raw),
		.count_error (count_raw)
	);

	// source levels; each is turned into a rising edge below
	always_comb begin
		link2_src = 8'h00;
		link2_src[BIT_CODEWORD] = codeword_stored;
		link2_src[BIT_RX_FULL]  = hdlc_mode ? rx_overrun_write
			: rx_fill_at_limit;
		link2_src[BIT_RX_NEAR]  = rx_fill_at_near;
		link2_src[BIT_MSG_RX]   = rx_msg_available;
		link2_src[BIT_TX_UNDER] = tx_fifo_drained && !tx_end_mark_seen;
		link2_src[BIT_TX_OVER]  = tx_write_while_full;
		link2_src[BIT_TX_NEAR]  = tx_below_near;
		link2_src[BIT_MSG_SENT] = tx_closing_flag;
		pattern_src = 8'h00;
		pattern_src[BIT_BIT_SLIP] = bit_slip_seen && bit_slip_enabled;
		pattern_src[BIT_PAT_SYNC] = sync_raw;
		pattern_src[BIT_TX_CRC]   = tx_crc_fail;
		pattern_src[BIT_TX_CAS]   = tx_cas_fail && cas_mode;
		pattern_src[BIT_TX_MF]    = tx_mf_fail;
		pattern_src[BIT_TX_FRAME] = tx_frame_fail;
		link2_prev_next = link2_src;
		pat_prev_next   = pattern_src;
	end

	////////////////////////////////////////////////////////////////////////////
	// status latches and enables

	logic [7:0] link2_stat_reg, link2_stat_next;
	logic [7:0] pat_stat_reg, pat_stat_next;
	logic [7:0] link2_en_reg, link2_en_next;
	logic [7:0] pat_en_reg, pat_en_next;
	logic [7:0] alarm1_en_reg, alarm1_en_next;
	logic [7:0] link2_rise, pat_rise;
	logic       rd_link2, rd_pat, wr_hit;

	// one latch step: a rise sets, a read clears, set wins
	function automatic logic [7:0] latch_step(input logic [7:0] cur,
		input logic [7:0] rise, input logic clr);
		latch_step = (clr ? 8'h00 : cur) | rise;
	endfunction

	always_comb begin
		link2_rise = link2_src & ~link2_prev_reg;
		pat_rise   = pattern_src & ~pat_prev_reg;
		rd_link2   = reg_sel && !reg_wr && reg_addr == ADDR_LINK2_STATUS;
		rd_pat     = reg_sel && !reg_wr && reg_addr == ADDR_PATTERN_STATUS;
		wr_hit     = reg_sel && reg_wr;
		// status sets regardless of enable
		link2_stat_next = latch_step(link2_stat_reg, link2_rise,
			rd_link2);
		pat_stat_next   = latch_step(pat_stat_reg, pat_rise,
			rd_pat) & PATTERN_MASK;
		link2_en_next  = link2_en_reg;
		pat_en_next    = pat_en_reg;
		alarm1_en_next = alarm1_en_reg;
		if (wr_hit && reg_addr == ADDR_LINK2_ENABLE)
			link2_en_next = reg_wdata;
		if (wr_hit && reg_addr == ADDR_PATTERN_ENABLE)
			pat_en_next = reg_wdata & PATTERN_MASK;
		if (wr_hit && reg_addr == ADDR_ALARM1_ENABLE)
			alarm1_en_next = reg_wdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all registered

	logic [7:0] rdata_next;
	logic [1:0] master_next;
	logic       abort_next, discard_next, frame_err_next, bit_err_next;
	logic       sync_next;

	// reads return the value held before the clear takes effect
	always_comb begin
		unique case (reg_addr)
			ADDR_LINK2_STATUS:   rdata_next = link2_stat_reg;
			ADDR_PATTERN_STATUS: rdata_next = pat_stat_reg;
			ADDR_ALARM1_ENABLE:  rdata_next = alarm1_en_reg;
			ADDR_LINK2_ENABLE:   rdata_next = link2_en_reg;
			ADDR_PATTERN_ENABLE: rdata_next = pat_en_reg;
			default:             rdata_next = 8'h00;
		endcase
		if (!(reg_sel && !reg_wr))
			rdata_next = reg_rdata;
		// master bits follow latched status through enables
		master_next[0] = |(link2_stat_next & link2_en_reg);
		master_next[1] = |(pat_stat_next & pat_en_reg);
		abort_next     = link2_src[BIT_TX_UNDER];
		discard_next   = tx_write_while_full;
		// a slip's apparent fas error is kept from the error paths
		frame_err_next = fas_error_raw && !pattern_src[BIT_BIT_SLIP];
		bit_err_next   = count_raw;
		// restart wins over a stale lock in the same cycle
		sync_next      = sync_raw && !pattern_restart;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			link2_prev_reg  <= 8'h00;
			pat_prev_reg    <= 8'h00;
			link2_stat_reg  <= RESET_STATUS;
			pat_stat_reg    <= RESET_STATUS;
			link2_en_reg    <= RESET_ENABLE;
			pat_en_reg      <= RESET_ENABLE;
			alarm1_en_reg   <= RESET_ENABLE;
			reg_rdata       <= 8'h00;
			master_interrupt_bits <= 2'b00;
			hdlc_abort      <= 1'b0;
			tx_data_discard <= 1'b0;
			frame_error_report <= 1'b0;
			pattern_bit_error_count <= 1'b0;
			pattern_sync    <= 1'b0;
		end else begin
			link2_prev_reg  <= link2_prev_next;
			pat_prev_reg    <= pat_prev_next;
			link2_stat_reg  <= link2_stat_next;
			pat_stat_reg    <= pat_stat_next;
			link2_en_reg    <= link2_en_next;
			pat_en_reg      <= pat_en_next;
			alarm1_en_reg   <= alarm1_en_next;
			reg_rdata       <= rdata_next;
			master_interrupt_bits <= master_next;
			hdlc_abort      <= abort_next;
			tx_data_discard <= discard_next;
			frame_error_report <= frame_err_next;
			pattern_bit_error_count <= bit_err_next;
			pattern_sync    <= sync_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	property p_link2_latch;
		@(posedge clk) disable iff (rst)
		(link2_src[BIT_TX_OVER] && !link2_prev_reg[BIT_TX_OVER])
			|=> link2_stat_reg[BIT_TX_OVER];
	endproperty
	a_link2_latch: assert property (p_link2_latch)
		else $error("link2 event not latched");

	property p_link2_hold;
		@(posedge clk) disable iff (rst)
		(link2_stat_reg[BIT_CODEWORD] && !rd_link2)
			|=> link2_stat_reg[BIT_CODEWORD];
	endproperty
	a_link2_hold: assert property (p_link2_hold)
		else $error("link2 status dropped without read");

	property p_set_wins;
		@(posedge clk) disable iff (rst)
		(rd_link2 && link2_rise[BIT_CODEWORD])
			|=> link2_stat_reg[BIT_CODEWORD];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("event lost on clearing read");

	property p_master_gate;
		@(posedge clk) disable iff (rst)
		(link2_en_reg == 8'h00) |=> !master_interrupt_bits[0];
	endproperty
	a_master_gate: assert property (p_master_gate)
		else $error("master bit without enabled status");

	property p_pat_master;
		@(posedge clk) disable iff (rst)
		|(pat_rise & pat_en_reg) |=> master_interrupt_bits[1];
	endproperty
	a_pat_master: assert property (p_pat_master)
		else $error("pattern master bit missing");

	property p_slip_hide;
		@(posedge clk) disable iff (rst)
		(bit_slip_seen && bit_slip_enabled) |=> !frame_error_report;
	endproperty
	a_slip_hide: assert property (p_slip_hide)
		else $error("slip leaked into frame errors");

	property p_no_count;
		@(posedge clk) disable iff (rst)
		!sync_raw |=> !pattern_bit_error_count;
	endproperty
	a_no_count: assert property (p_no_count)
		else $error("errors counted without sync");

	property p_cas_only;
		@(posedge clk) disable iff (rst)
		(!cas_mode && !pat_stat_reg[BIT_TX_CAS] && !rd_pat)
			|=> !pat_stat_reg[BIT_TX_CAS];
	endproperty
	a_cas_only: assert property (p_cas_only)
		else $error("cas error outside cas mode");

	property p_abort;
		@(posedge clk) disable iff (rst)
		(tx_fifo_drained && !tx_end_mark_seen) |=> hdlc_abort;
	endproperty
	a_abort: assert property (p_abort)
		else $error("underrun without abort");

	property p_discard;
		@(posedge clk) disable iff (rst)
		tx_write_while_full |=> tx_data_discard;
	endproperty
	a_discard: assert property (p_discard)
		else $error("write to full fifo not discarded");

	property p_restart_drop;
		@(posedge clk) disable iff (rst)
		pattern_restart |=> !pattern_sync;
	endproperty
	a_restart_drop: assert property (p_restart_drop)
		else $error("pattern sync kept through restart");

endmodule
`default_nettype wire

/* tb/host_port_model.sv */
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// host side of the parallel register port
module host_port_model (
	// clock
	input  wire logic       clk,
	// register port
	output logic            reg_sel,
	output logic            reg_wr,
	output logic      [8:0] reg_addr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	// idle bus at time zero
	initial begin
		reg_sel = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 9'h1ff;
		reg_wdata = 8'h00;
	end

	// one access held over one rising edge; read data sampled at the next falling edge
	// on release the address and write data are inverted so no one leans on stale values
	task automatic access(input logic w, input logic [8:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		reg_sel = 1'b1;
		reg_wr = w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		q = reg_rdata;
		reg_sel = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module tb;
	import link2_irq_pkg::*;
	// stimulus and observed signals
	logic       clk = 1'b0, rst = 1'b1, restart = 1'b0, pvalid = 1'b0;
	logic       perr = 1'b0, hdlc = 1'b1, eom = 1'b0, slip_en = 1'b1;
	logic       fas = 1'b0, cas = 1'b1, lim = 1'b0;
	logic       reg_sel, reg_wr, abort, discard, frame_rep, cnt_pulse;
	logic       pat_sync;
	logic [8:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, q;
	logic [7:0] l2 = 8'h00;
	logic [5:0] pt = 6'h00;
	logic [1:0] mib;
	int         err_count = 0, total_checks = 0, counted = 0;

	always #4 clk = ~clk;

	host_port_model host (.clk(clk), .reg_sel(reg_sel), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	framer_link2_pattern_irq_status dut (.clk(clk), .rst(rst),
		.reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.codeword_stored(l2[7]), .hdlc_mode(hdlc), .rx_overrun_write(l2[6]),
		.rx_fill_at_limit(lim), .rx_fill_at_near(l2[5]),
		.rx_msg_available(l2[4]), .tx_fifo_drained(l2[3]),
		.tx_end_mark_seen(eom), .tx_write_while_full(l2[2]),
		.tx_below_near(l2[1]), .tx_closing_flag(l2[0]),
		.bit_slip_seen(pt[5]), .bit_slip_enabled(slip_en),
		.fas_error_raw(fas), .pattern_restart(restart),
		.pattern_bit_valid(pvalid), .pattern_bit_error(perr),
		.tx_crc_fail(pt[3]), .tx_cas_fail(pt[2]), .cas_mode(cas),
		.tx_mf_fail(pt[1]), .tx_frame_fail(pt[0]), .hdlc_abort(abort),
		.tx_data_discard(discard), .frame_error_report(frame_rep),
		.pattern_bit_error_count(cnt_pulse), .pattern_sync(pat_sync),
		.master_interrupt_bits(mib));

	// own tally of counted errors, compared against the expected error counts
	always @(posedge clk) begin
		if (cnt_pulse === 1'b1) counted++;
	end

	////////////////////////////////////////////////////////////////////////
	// compare helper
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: saw %h expected %h",
				$time, seen, exp);
		end
	endtask

	// verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// read one register and compare
	task automatic rd(input logic [8:0] a, input logic [7:0] exp);
		host.access(1'b0, a, 8'h00, q);
		chk(q, exp);
	endtask

	// received pattern bits, every e-th one errored (none for e of 0)
	task automatic bits(input int n, input int e);
		for (int i = 1; i <= n; i++) begin
			@(negedge clk);
			pvalid = 1'b1;
			perr = (e != 0) && (i % e == 0);
		end
		@(negedge clk);
		pvalid = 1'b0;
		perr = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	// pulse the sync search restart
	task automatic restart_search();
		@(negedge clk);
		restart = 1'b1;
		@(negedge clk);
		restart = 1'b0;
	endtask

	// a hang is cut short here
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		close_out();
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		// reset values, unmapped and read-only places
		host.access(1'b1, ADDR_LINK2_STATUS, 8'hff, q);
		foreach (l2[i]) begin
			rd(9'h00a + 9'(i), 8'h00);
		end
		host.access(1'b1, ADDR_ALARM1_ENABLE, 8'ha5, q);
		rd(ADDR_ALARM1_ENABLE, 8'ha5);
		$display("test registers done");
		// underrun with end mark seen is no event
		eom = 1'b1;
		l2[3] = 1'b1;
		repeat (2) @(negedge clk);
		chk({7'h00, abort}, 8'h00);
		l2[3] = 1'b0;
		eom = 1'b0;
		rd(ADDR_LINK2_STATUS, 8'h00);
		// every link2 event, enabled
		host.access(1'b1, ADDR_LINK2_ENABLE, 8'hff, q);
		for (int b = 0; b < 8; b++) begin
			l2[b] = 1'b1;
			repeat (2) @(negedge clk);
			chk({7'h00, mib[0]}, 8'h01);
			if (b == 2) chk({7'h00, discard}, 8'h01);
			if (b == 3) chk({7'h00, abort}, 8'h01);
			rd(ADDR_LINK2_STATUS, 8'h01 << b);
			l2[b] = 1'b0;
			rd(ADDR_LINK2_STATUS, 8'h00);
			chk({6'h00, mib}, 8'h00);
		end
		// rx full follows the overrun only in hdlc, the fill limit otherwise
		lim = 1'b1;
		rd(ADDR_LINK2_STATUS, 8'h00);
		lim = 1'b0;
		hdlc = 1'b0;
		@(negedge clk);
		lim = 1'b1;
		rd(ADDR_LINK2_STATUS, 8'h40);
		// disabled: status still sets, master stays low
		host.access(1'b1, ADDR_LINK2_ENABLE, 8'h00, q);
		l2[0] = 1'b1;
		repeat (2) @(negedge clk);
		chk({6'h00, mib}, 8'h00);
		rd(ADDR_LINK2_STATUS, 8'h01);
		// a rise in the clearing read cycle survives the read
		fork
			rd(ADDR_LINK2_STATUS, 8'h00);
			begin
				@(negedge clk);
				l2[7] = 1'b1;
			end
		join
		rd(ADDR_LINK2_STATUS, 8'h80);
		$display("test link2 events done");
		// pattern events, enabled
		host.access(1'b1, ADDR_PATTERN_ENABLE, 8'hff, q);
		rd(ADDR_PATTERN_ENABLE, 8'h3f);
		for (int b = 0; b < 6; b++) begin
			if (b == 4) continue;
			pt[b] = 1'b1;
			repeat (2) @(negedge clk);
			chk({7'h00, mib[1]}, 8'h01);
			rd(ADDR_PATTERN_STATUS, 8'h01 << b);
			pt[b] = 1'b0;
			rd(ADDR_PATTERN_STATUS, 8'h00);
		end
		// cas error only in cas mode
		cas = 1'b0;
		pt[2] = 1'b1;
		rd(ADDR_PATTERN_STATUS, 8'h00);
		// alignment error hidden while an enabled slip is present
		pt[5] = 1'b1;
		fas = 1'b1;
		repeat (2) @(negedge clk);
		chk({7'h00, frame_rep}, 8'h00);
		slip_en = 1'b0;
		repeat (2) @(negedge clk);
		chk({7'h00, frame_rep}, 8'h01);
		fas = 1'b0;
		rd(ADDR_PATTERN_STATUS, 8'h20);
		$display("test pattern events done");
		// error-laden pattern never syncs and is never counted
		restart_search();
		bits(300, 50);
		chk({7'h00, pat_sync}, 8'h00);
		chk(8'(counted), 8'h00);
		// clean run, but not before the minimum bit count
		restart_search();
		bits(127, 0);
		chk({7'h00, pat_sync}, 8'h00);
		bits(1, 0);
		for (int i = 0; i < 8 && pat_sync !== 1'b1; i++) @(negedge clk);
		chk({7'h00, pat_sync}, 8'h01);
		rd(ADDR_PATTERN_STATUS, 8'h10);
		// once synced, errors are counted and sync is kept
		bits(10, 2);
		chk(8'(counted), 8'h05);
		chk({7'h00, pat_sync}, 8'h01);
		restart_search();
		@(negedge clk);
		chk({7'h00, pat_sync}, 8'h00);
		$display("test pattern sync done");
		close_out();
	end
endmodule
`default_nettype wire
